// >>> core/sal_supply_alert.sv
// Function
// - Supply flags stay latched; writing one clears a bit, writing zero leaves it.
// - Calibration upload checksum or uncorrectable error sets the calibration fault, bit 6.
// - A register access before the refresh finishes also sets the calibration fault.
// - Output-stage supply below 9.3 V latches the bit 5 flag.
// - Internal regulator below 1.4 V latches its fault flag.
// - Analog low-voltage rail below 4.1 V latches its fault flag.
// - Logic supply below 1.9 V latches its fault flag.
// - Negative supply rising above -1.6V latches its fault flag.
// - Positive analog supply below 5.5 V latches its fault flag.
// - A general gate bit at one keeps its alert condition off the pin.
// - A supply gate bit at one keeps its fault flag off the pin.
// - Gating only affects the pin; status bits still latch.
// - General gate bits sit at positions 14 down to 2 as listed.
// - Each supply gate bit sits at the position of the flag it gates.
// - An unlatched summary shows whether any supply flag is set.
`timescale 1ns/10ps
module sal_supply_alert (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port from the serial decoder
	input wire sal_pkg::sal_reg_req_t reg_req,
	output logic [15:0] reg_rdata_q,
	output logic reg_rvalid_q,
	// Supply monitors and calibration loader
	input wire sal_pkg::sal_supply_mon_t supply_mon,
	input wire logic cal_load_error,
	input wire logic cal_refresh_done,
	// Latched general alert conditions
	input wire logic [15:0] general_status,
	// Open-drain alert pin and live summary
	output logic alert_n_o,
	output logic alert_oe,
	output logic supply_summary
);

	logic [15:0] flags_q;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] general_gate_q;
	logic [15:0] general_gate_d;
	logic [15:0] supply_gate_q;
	logic [15:0] supply_gate_d;
	logic [15:0] reg_rdata_d;
	logic reg_rvalid_d;
	logic alert_q;
	logic alert_d;
	logic access;
	logic early_access;

	assign access = reg_req.wr | reg_req.rd;
	assign early_access = access & ~cal_refresh_done;

	// Hardware events build the set vector; the monitor levels are latched every cycle they hold.
	always_comb begin
		flag_set = 16'h0000;
		flag_set[sal_pkg::CAL_MEM_BIT] = cal_load_error | early_access;
		flag_set[sal_pkg::OUTPUT_STAGE_BIT] = supply_mon.output_stage_low;
		flag_set[sal_pkg::INTERNAL_REGULATOR_BIT] = supply_mon.internal_regulator_low;
		flag_set[sal_pkg::ANALOG_LOW_RAIL_BIT] = supply_mon.analog_low_rail_low;
		flag_set[sal_pkg::LOGIC_SUPPLY_BIT] = supply_mon.logic_supply_low;
		flag_set[sal_pkg::NEGATIVE_SUPPLY_BIT] = supply_mon.negative_supply_high;
		flag_set[sal_pkg::POSITIVE_SUPPLY_BIT] = supply_mon.positive_supply_low;
		flag_clr = 16'h0000;
		if (reg_req.wr && cal_refresh_done && reg_req.addr == sal_pkg::SUPPLY_FLAGS_ADDR) begin
			flag_clr = reg_req.wdata & sal_pkg::SUPPLY_USED;
		end
	end

	sal_flag_bank #(
		.WIDTH(16)
	) u_flags (
		.clk_sys(clk_sys),
		.rst(rst),
		.set_i(flag_set),
		.clr_i(flag_clr),
		.flags_q(flags_q)
	);

	// Accesses made before the refresh completes change no register, and reads are answered with zero; both are flagged.
	always_comb begin
		general_gate_d = general_gate_q;
		supply_gate_d = supply_gate_q;
		reg_rdata_d = reg_rdata_q;
		reg_rvalid_d = 1'b0;
		if (reg_req.wr && cal_refresh_done) begin
			if (reg_req.addr == sal_pkg::GENERAL_GATE_ADDR) begin
				general_gate_d = reg_req.wdata & sal_pkg::GENERAL_USED;
			end
			if (reg_req.addr == sal_pkg::SUPPLY_GATE_ADDR) begin
				supply_gate_d = reg_req.wdata & sal_pkg::SUPPLY_USED;
			end
		end
		if (reg_req.rd) begin
			reg_rvalid_d = 1'b1;
			reg_rdata_d = 16'h0000;
			if (cal_refresh_done) begin
				case (reg_req.addr)
					sal_pkg::SUPPLY_FLAGS_ADDR: begin
						reg_rdata_d = flags_q;
					end
					sal_pkg::GENERAL_GATE_ADDR: begin
						reg_rdata_d = general_gate_q;
					end
					sal_pkg::SUPPLY_GATE_ADDR: begin
						reg_rdata_d = supply_gate_q;
					end
					default: begin
						reg_rdata_d = 16'h0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			general_gate_q <= sal_pkg::REG_RESET;
			supply_gate_q <= sal_pkg::REG_RESET;
			reg_rdata_q <= sal_pkg::REG_RESET;
			reg_rvalid_q <= 1'b0;
		end else begin
			general_gate_q <= general_gate_d;
			supply_gate_q <= supply_gate_d;
			reg_rdata_q <= reg_rdata_d;
			reg_rvalid_q <= reg_rvalid_d;
		end
	end

	// The gates act only here, after the flags, so masked events still latch.
	always_comb begin
		alert_d = (|(flags_q & ~supply_gate_q))
			| (|(general_status & sal_pkg::GENERAL_USED & ~general_gate_q));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= alert_d;
		end
	end

	// Open-drain pin: drive low only while asserting.
	assign alert_n_o = 1'b0;
	assign alert_oe = alert_q;
	// Left unregistered so a live summary never lags the latched flags by a cycle.
	assign supply_summary = |flags_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_clear_write(int b);
		reg_req.wr && cal_refresh_done && reg_req.addr == sal_pkg::SUPPLY_FLAGS_ADDR && reg_req.wdata[b];
	endsequence

	sequence s_no_cal_event;
		!cal_load_error && !early_access;
	endsequence

	sequence s_ungated_flag;
		flags_q[sal_pkg::OUTPUT_STAGE_BIT] && !supply_gate_q[sal_pkg::OUTPUT_STAGE_BIT];
	endsequence

	sequence s_flag_read;
		reg_req.rd && cal_refresh_done && reg_req.addr == sal_pkg::SUPPLY_FLAGS_ADDR;
	endsequence

	a_w1c_clear: assert property (s_clear_write(6) and s_no_cal_event |=> !flags_q[6])
		else $error("Calibration flag not cleared by write of one.");
	a_zero_keeps: assert property (flags_q[5] && !flag_clr[5] |=> flags_q[5])
		else $error("Flag lost without a clearing write.");
	a_cal_load: assert property (cal_load_error |=> flags_q[6] && supply_summary)
		else $error("Calibration load error not latched.");
	a_early_access: assert property (access && !cal_refresh_done
		|=> flags_q[6] && (!reg_rvalid_q || reg_rdata_q == 16'h0000))
		else $error("Early access not flagged.");
	a_stage_latch: assert property (supply_mon.output_stage_low ##1 !supply_mon.output_stage_low |-> flags_q[5])
		else $error("Output stage fault not latched.");
	a_regulator_latch: assert property (supply_mon.internal_regulator_low |=> flags_q[4])
		else $error("Regulator fault not latched.");
	a_low_rail_latch: assert property (supply_mon.analog_low_rail_low |=> flags_q[3])
		else $error("Analog low rail fault not latched.");
	a_logic_latch: assert property (supply_mon.logic_supply_low |=> flags_q[2])
		else $error("Logic supply fault not latched.");
	a_negative_latch: assert property (supply_mon.negative_supply_high |=> flags_q[1])
		else $error("Negative supply fault not latched.");
	a_positive_latch: assert property (supply_mon.positive_supply_low |=> flags_q[0])
		else $error("Positive supply fault not latched.");
	a_general_gated: assert property (general_gate_q == 16'h7FFC && supply_gate_q == 16'h007F |=> !alert_oe)
		else $error("Gated conditions reached the pin.");
	a_supply_gated: assert property (flags_q != 16'h0000 && (flags_q & ~supply_gate_q) == 16'h0000
		&& (general_status & ~general_gate_q & 16'h7FFC) == 16'h0000 |=> !alert_oe)
		else $error("Gated supply flag reached the pin.");
	a_gated_latch: assert property (supply_gate_q[0] && supply_mon.positive_supply_low |=> flags_q[0])
		else $error("Gated event failed to latch.");
	a_gate_layout: assert property (general_gate_q[15] == 1'b0 && general_gate_q[1:0] == 2'b00
		&& supply_gate_q[15:7] == 9'h000)
		else $error("Gate register reserved bits set.");
	a_summary_live: assert property (supply_summary == (flags_q != 16'h0000))
		else $error("Supply summary wrong.");
	a_alert_follows: assert property (s_ungated_flag |=> alert_oe && !alert_n_o)
		else $error("Ungated flag did not assert pin.");
	a_alert_release: assert property (flags_q == 16'h0000 && (general_status & 16'h7FFC) == 16'h0000 |=> !alert_oe)
		else $error("Pin not released.");
	// A clear is only honoured once the monitor has let go, otherwise the set wins.
	a_stage_clear: assert property (s_clear_write(5) and !supply_mon.output_stage_low |=> !flags_q[5])
		else $error("Output stage flag not cleared by write of one.");
	a_flag_read: assert property (s_flag_read |=> reg_rvalid_q && reg_rdata_q == $past(flags_q))
		else $error("Flag read returned wrong data.");
	a_early_write: assert property (reg_req.wr && !cal_refresh_done
		|=> $stable(general_gate_q) && $stable(supply_gate_q))
		else $error("Early write changed a gate.");
	a_read_answer: assert property (reg_req.rd |=> reg_rvalid_q)
		else $error("Read not answered.");
	a_answer_pulse: assert property (!reg_req.rd |=> !reg_rvalid_q)
		else $error("Answer without a read.");
	a_general_pin: assert property (general_status[sal_pkg::SERIAL_ERROR_GATE]
		&& !general_gate_q[sal_pkg::SERIAL_ERROR_GATE] |=> alert_oe)
		else $error("Ungated general condition did not assert pin.");

endmodule

// >>> core/sal_pkg.sv
package sal_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	// Register offsets on the serial register port.
	localparam logic [7:0] SUPPLY_FLAGS_ADDR = 8'h5B;
	localparam logic [7:0] GENERAL_GATE_ADDR = 8'h5F;
	localparam logic [7:0] SUPPLY_GATE_ADDR = 8'h60;

	localparam logic [15:0] REG_RESET = 16'h0000;

	// Supply fault flag positions, shared by the flag and gate registers.
	localparam int CAL_MEM_BIT = 6;
	localparam int OUTPUT_STAGE_BIT = 5;
	localparam int INTERNAL_REGULATOR_BIT = 4;
	localparam int ANALOG_LOW_RAIL_BIT = 3;
	localparam int LOGIC_SUPPLY_BIT = 2;
	localparam int NEGATIVE_SUPPLY_BIT = 1;
	localparam int POSITIVE_SUPPLY_BIT = 0;
	localparam logic [15:0] SUPPLY_USED = 16'h007F;

	// General alert gate positions.
	localparam int ANALOG_OPEN_CIRCUIT_GATE = 14;
	localparam int ANALOG_SHORT_CIRCUIT_GATE = 13;
	localparam int OUTPUT_INTERNAL_TIMEOUT_GATE = 12;
	localparam int OUTPUT_EXTERNAL_TIMEOUT_GATE = 11;
	localparam int OUTPUT_INTERNAL_SHORT_GATE = 10;
	localparam int OUTPUT_EXTERNAL_SHORT_GATE = 9;
	localparam int OUTPUT_THERMAL_RESET_GATE = 8;
	localparam int INPUT_OPEN_CIRCUIT_GATE = 7;
	localparam int INPUT_SHORT_CIRCUIT_GATE = 6;
	localparam int CONVERTER_ERROR_GATE = 5;
	localparam int TEMPERATURE_GATE = 4;
	localparam int POWER_CONTROL_ERROR_GATE = 3;
	localparam int SERIAL_ERROR_GATE = 2;
	localparam logic [15:0] GENERAL_USED = 16'h7FFC;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sal_reg_req_t;

	typedef struct packed {
		logic output_stage_low;
		logic internal_regulator_low;
		logic analog_low_rail_low;
		logic logic_supply_low;
		logic negative_supply_high;
		logic positive_supply_low;
	} sal_supply_mon_t;

endpackage

// >>> core/sal_flag_bank.sv
`timescale 1ns/10ps
module sal_flag_bank #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Set and clear strobes
	input wire logic [WIDTH-1:0] set_i,
	input wire logic [WIDTH-1:0] clr_i,
	// Latched flags
	output logic [WIDTH-1:0] flags_q
);

	logic [WIDTH-1:0] flags_d;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("Flag bank needs at least one bit.");
		end
	endgenerate

	// A set in the same cycle as its clear wins, so no event is lost.
	always_comb begin
		flags_d = (flags_q & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule

// >>> tb/sal_host_model.sv
`timescale 1ns/10ps
module sal_host_model (
	// Clock and device state
	input wire logic clk_sys,
	input wire logic cal_refresh_done,
	// Register port
	output sal_pkg::sal_reg_req_t reg_req,
	input wire logic [15:0] reg_rdata_q,
	input wire logic reg_rvalid_q
);
	initial reg_req = '0;
	// Early is set only by the scenario that probes refused accesses.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic early, output logic [15:0] q, output logic ok);
		int n;
		n = 0;
		q = 16'h0000;
		while (!early && !cal_refresh_done && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_sys);
		// Released lines show the inverse, so a stale value never looks valid.
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		ok = (n < 50) && (w || reg_rvalid_q);
		if (!w) begin
			q = reg_rdata_q;
		end
	endtask
endmodule

// >>> tb/tb_supply_alert_latch_and_mask.sv
`timescale 1ns/10ps
module tb_supply_alert_latch_and_mask;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic done = 1'b0;
	logic cal_err = 1'b0;
	logic [15:0] gs = 16'h0000;
	sal_pkg::sal_supply_mon_t mon = '0;
	sal_pkg::sal_reg_req_t req;
	logic [15:0] rdata;
	logic rvalid;
	logic alert_oe;
	logic alert_n;
	logic summary;
	logic [15:0] q;
	logic [15:0] sg;
	logic [15:0] gg;
	logic [15:0] fl;
	logic ok;
	logic [31:0] seed = 32'h2752741A;
	int n_mismatch = 0;
	int n_compared = 0;
	always #5 clk_sys = ~clk_sys;
	sal_supply_alert i_dut (.clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata_q(rdata),
		.reg_rvalid_q(rvalid), .supply_mon(mon), .cal_load_error(cal_err),
		.cal_refresh_done(done), .general_status(gs), .alert_n_o(alert_n), .alert_oe(alert_oe),
		.supply_summary(summary));
	sal_host_model i_host (.clk_sys(clk_sys), .cal_refresh_done(done), .reg_req(req),
		.reg_rdata_q(rdata), .reg_rvalid_q(rvalid));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] want(input logic [15:0] f, g, s, h);
		return 16'(|((f & ~g & 16'h007F) | (s & 16'h7FFC & ~h)));
	endfunction
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		i_host.xfer(1'b0, a, 16'h0000, 1'b0, q, ok);
		chk(what, exp, q);
		if (!ok) begin
			chk("read answer", 16'h0001, 16'h0000);
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host.xfer(1'b1, a, d, 1'b0, q, ok);
		if (!ok) begin
			chk("write answer", 16'h0001, 16'h0000);
			report_and_stop();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	initial begin
		tick(20);
		rst = 1'b0;
		i_host.xfer(1'b0, sal_pkg::SUPPLY_FLAGS_ADDR, 16'h0000, 1'b1, q, ok);
		chk("early read", 16'h0000, q);
		chk("early answer", 16'h0001, 16'(ok));
		i_host.xfer(1'b1, sal_pkg::SUPPLY_GATE_ADDR, 16'h007F, 1'b1, q, ok);
		tick(2);
		chk("cal alert", 16'h0001, 16'(alert_oe));
		done = 1'b1;
		rd(sal_pkg::SUPPLY_GATE_ADDR, 16'h0000, "early write");
		rd(sal_pkg::SUPPLY_FLAGS_ADDR, 16'h0040, "cal flag");
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		rd(sal_pkg::SUPPLY_FLAGS_ADDR, 16'h0000, "flags reset");
		rd(sal_pkg::GENERAL_GATE_ADDR, 16'h0000, "general reset");
		rd(sal_pkg::SUPPLY_GATE_ADDR, 16'h0000, "supply reset");
		rd(8'h5C, 16'h0000, "unmapped");
		chk("alert reset", 16'h0000, 16'(alert_oe));
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			fl = 16'h0001 << i;
			cal_err = (i == 6);
			mon = fl[5:0];
			tick(1);
			chk("summary", 16'h0001, 16'(summary));
			wr(sal_pkg::SUPPLY_FLAGS_ADDR, fl);
			rd(sal_pkg::SUPPLY_FLAGS_ADDR, fl, "held flag");
			chk("flag alert", 16'h0001, 16'(alert_oe));
			chk("pin level", 16'h0000, 16'(alert_n));
			mon = '0;
			cal_err = 1'b0;
			wr(sal_pkg::SUPPLY_FLAGS_ADDR, ~fl);
			rd(sal_pkg::SUPPLY_FLAGS_ADDR, fl, "zero write");
			wr(sal_pkg::SUPPLY_FLAGS_ADDR, fl);
			rd(sal_pkg::SUPPLY_FLAGS_ADDR, 16'h0000, "cleared");
			tick(2);
			chk("alert off", 16'h0000, 16'(alert_oe));
			chk("summary off", 16'h0000, 16'(summary));
		end
		$display("test flags done");
		for (int k = 0; k < 24; k++) begin
			seed = lfsr(seed);
			sg = (k == 0) ? 16'hFFFF : seed[15:0];
			gg = (k == 0) ? 16'hFFFF : seed[31:16];
			wr(sal_pkg::SUPPLY_GATE_ADDR, sg);
			wr(sal_pkg::GENERAL_GATE_ADDR, gg);
			rd(sal_pkg::GENERAL_GATE_ADDR, gg & 16'h7FFC, "general gate");
			rd(sal_pkg::SUPPLY_GATE_ADDR, sg & 16'h007F, "supply gate");
			seed = lfsr(seed);
			mon = (k == 0) ? 6'h3F : seed[5:0];
			gs = seed[31:16] & 16'h7FFC;
			fl = {10'h000, mon};
			tick(1);
			mon = '0;
			tick(2);
			chk("gated alert", want(fl, sg, gs, gg), 16'(alert_oe));
			rd(sal_pkg::SUPPLY_FLAGS_ADDR, fl, "gated flags");
			wr(sal_pkg::SUPPLY_FLAGS_ADDR, 16'h007F);
		end
		$display("test gating done");
		report_and_stop();
	end
endmodule
